// ===== compare_timer.sv
/*
  Eight-bit compare timer with match/wrap flags, output-pin control, an
  AXI4-Lite register slave and a masked level interrupt.
  Assumes one clock, sys_clk, and an external count pin asynchronous to it.
*/
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module compare_timer (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic ext_count_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic timer_output_pin,
  output logic irq
);
  typedef struct packed {
    logic [7:0] count_register;
    logic [7:0] compare_reg_a;
    logic [7:0] compare_reg_b;
    logic match_b_flag;
    logic match_a_flag;
    logic wrap_flag;
    logic [1:0] out_select;
    logic [2:0] clock_sel;
    logic internal_clock_sel;
    logic [2:0] armed;
    logic [2:0] irq_mask;
    logic pin;
    logic [6:0] prescale;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic ext_rise;
  logic ext_fall;
  logic tick;
  logic [7:0] status_byte;
  logic [2:0] flags;
  logic do_write;
  logic do_read;

  edge_sync u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .async_in(ext_count_in),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  // Falling-edge detect of one prescaler bit, from current and next value.
  function automatic logic div_fall(input logic [6:0] cur,
                                    input logic [6:0] nxt,
                                    input int idx);
    div_fall = cur[idx] & ~nxt[idx];
  endfunction

  // Write merge of one byte lane under its strobe.
  function automatic logic [7:0] lane0(input logic [7:0] old,
                                       input logic [31:0] d,
                                       input logic [3:0] s);
    lane0 = s[0] ? d[7:0] : old;
  endfunction

  // Count-tick selection from the clock-select fields.
  always_comb begin
    logic [6:0] pnext;
    pnext = 7'(st_reg.prescale + 7'h01);
    tick = 1'b0;
    unique case ({st_reg.clock_sel, st_reg.internal_clock_sel})
      4'b0010: tick = div_fall(st_reg.prescale, pnext, 1);
      4'b0011: tick = div_fall(st_reg.prescale, pnext, 2);
      4'b0100: tick = div_fall(st_reg.prescale, pnext, 3);
      4'b0101: tick = div_fall(st_reg.prescale, pnext, 4);
      4'b0110: tick = div_fall(st_reg.prescale, pnext, 5);
      4'b0111: tick = div_fall(st_reg.prescale, pnext, 6);
      4'b1010, 4'b1011: tick = ext_rise;
      4'b1100, 4'b1101: tick = ext_fall;
      4'b1110, 4'b1111: tick = ext_rise | ext_fall;
      default: tick = 1'b0;
    endcase
  end

  // Status byte as software sees it; bit 4 is fixed high.
  always_comb begin
    status_byte = timer_pkg::STATUS_RESET;
    status_byte[timer_pkg::MATCH_B_POS] = st_reg.match_b_flag;
    status_byte[timer_pkg::MATCH_A_POS] = st_reg.match_a_flag;
    status_byte[timer_pkg::WRAP_POS] = st_reg.wrap_flag;
    status_byte[timer_pkg::OSEL_HI_POS] = st_reg.out_select[1];
    status_byte[timer_pkg::OSEL_LO_POS] = st_reg.out_select[0];
  end

  assign flags = {st_reg.match_b_flag, st_reg.match_a_flag,
                  st_reg.wrap_flag};
  assign do_write = st_reg.aw_held & st_reg.w_held & ~st_reg.bvalid;
  assign do_read = s_axi_arvalid & ~st_reg.rvalid;

  // Handshake outputs: accept each write channel once, reads when idle.
  assign s_axi_awready = ~st_reg.aw_held & ~st_reg.bvalid;
  assign s_axi_wready = ~st_reg.w_held & ~st_reg.bvalid;
  assign s_axi_arready = ~st_reg.rvalid;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = st_reg.rdata;
  assign timer_output_pin = st_reg.pin;
  // Interrupt is a level, so it follows the sticky flags under irq_mask directly.
  assign irq = |(flags & st_reg.irq_mask);

  // Main next-state logic: counter, flags, pin and the register slave.
  always_comb begin
    logic [2:0] clr;
    logic [2:0] set;
    logic [7:0] wb;
    logic mb;
    logic ma;
    logic wr;
    st_next = st_reg;
    clr = 3'h0;
    set = 3'h0;
    wb = 8'h00;
    mb = 1'b0;
    ma = 1'b0;
    wr = 1'b0;
    st_next.prescale = 7'(st_reg.prescale + 7'h01);

    // Counting: a match is judged on the value a tick produces, so a
    // counter parked on a compare value (as after reset) does not keep
    // re-setting a flag that software has just cleared.
    if (tick) begin
      st_next.count_register = 8'(st_reg.count_register + 8'h01);
      wr = (st_reg.count_register == timer_pkg::COUNT_MAX);
      mb = (st_next.count_register == st_reg.compare_reg_b);
      ma = (st_next.count_register == st_reg.compare_reg_a);
    end
    set = {mb, ma, wr};
    // A status read arms each flag it returned as one for a later clear.
    if (do_read && s_axi_araddr == timer_pkg::STATUS_OFF) begin
      st_next.armed = st_reg.armed | flags;
    end

    // Pin action on a match B event.
    if (set[2]) begin
      unique case (st_reg.out_select)
        timer_pkg::OSEL_NONE: st_next.pin = st_reg.pin;
        timer_pkg::OSEL_LOW: st_next.pin = 1'b0;
        timer_pkg::OSEL_HIGH: st_next.pin = 1'b1;
        timer_pkg::OSEL_TOGGLE: st_next.pin = ~st_reg.pin;
      endcase
    end

    // Capture write address and data in whichever order they come.
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end

    // Register write once both halves are held.
    if (do_write) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = timer_pkg::RESP_OKAY;
      unique case (st_reg.aw_addr)
        timer_pkg::STATUS_OFF: begin
          wb = lane0(status_byte, st_reg.w_data, st_reg.w_strb);
          // A zero clears a flag only if it was read as one first.
          clr = ~{wb[timer_pkg::MATCH_B_POS], wb[timer_pkg::MATCH_A_POS],
                  wb[timer_pkg::WRAP_POS]} & st_reg.armed;
          st_next.armed = 3'h0;
          st_next.out_select = wb[timer_pkg::OSEL_HI_POS:
                                  timer_pkg::OSEL_LO_POS];
        end
        timer_pkg::CONTROL_OFF: begin
          wb = lane0({4'h0, st_reg.clock_sel, st_reg.internal_clock_sel},
                     st_reg.w_data, st_reg.w_strb);
          st_next.clock_sel = wb[3:1];
          st_next.internal_clock_sel = wb[0];
        end
        timer_pkg::COUNT_OFF:
          st_next.count_register = lane0(st_reg.count_register,
                                         st_reg.w_data, st_reg.w_strb);
        timer_pkg::CMPA_OFF:
          st_next.compare_reg_a = lane0(st_reg.compare_reg_a,
                                        st_reg.w_data, st_reg.w_strb);
        timer_pkg::CMPB_OFF:
          st_next.compare_reg_b = lane0(st_reg.compare_reg_b,
                                        st_reg.w_data, st_reg.w_strb);
        timer_pkg::IRQ_MASK_OFF: begin
          wb = lane0({5'h00, st_reg.irq_mask}, st_reg.w_data, st_reg.w_strb);
          st_next.irq_mask = wb[2:0];
        end
        timer_pkg::IRQ_STAT_OFF: begin
          // Write-one-to-clear view of the same sticky flags.
          wb = lane0(8'h00, st_reg.w_data, st_reg.w_strb);
          clr = wb[2:0];
        end
        default: st_next.bresp = timer_pkg::RESP_SLVERR;
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // Read path: data registered, answered one cycle after address.
    if (do_read) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = timer_pkg::RESP_OKAY;
      st_next.rdata = 32'h00000000;
      unique case (s_axi_araddr)
        timer_pkg::STATUS_OFF: begin
          st_next.rdata = {24'h000000, status_byte};
        end
        timer_pkg::CONTROL_OFF:
          st_next.rdata = {28'h0000000, st_reg.clock_sel,
                           st_reg.internal_clock_sel};
        timer_pkg::COUNT_OFF:
          st_next.rdata = {24'h000000, st_reg.count_register};
        timer_pkg::CMPA_OFF:
          st_next.rdata = {24'h000000, st_reg.compare_reg_a};
        timer_pkg::CMPB_OFF:
          st_next.rdata = {24'h000000, st_reg.compare_reg_b};
        timer_pkg::IRQ_MASK_OFF:
          st_next.rdata = {29'h00000000, st_reg.irq_mask};
        timer_pkg::IRQ_STAT_OFF:
          st_next.rdata = {29'h00000000, flags};
        default: st_next.rresp = timer_pkg::RESP_SLVERR;
      endcase
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end

    // Flag update; a simultaneous event beats the clear.
    st_next.match_b_flag = set[2] | (st_reg.match_b_flag & ~clr[2]);
    st_next.match_a_flag = set[1] | (st_reg.match_a_flag & ~clr[1]);
    st_next.wrap_flag = set[0] | (st_reg.wrap_flag & ~clr[0]);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end
endmodule

// ===== timer_pkg.sv
/*
  Shared constants for the 8-bit compare timer: register byte offsets,
  field positions, reset values and output-select encodings.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package timer_pkg;
  localparam logic [7:0] STATUS_OFF = 8'h00;
  localparam logic [7:0] CONTROL_OFF = 8'h04;
  localparam logic [7:0] COUNT_OFF = 8'h08;
  localparam logic [7:0] CMPA_OFF = 8'h0c;
  localparam logic [7:0] CMPB_OFF = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h14;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h18;
  localparam int MATCH_B_POS = 7;
  localparam int MATCH_A_POS = 6;
  localparam int WRAP_POS = 5;
  localparam int RSVD_POS = 4;
  localparam int OSEL_HI_POS = 3;
  localparam int OSEL_LO_POS = 2;
  localparam logic [7:0] STATUS_RESET = 8'h10;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [1:0] OSEL_NONE = 2'h0;
  localparam logic [1:0] OSEL_LOW = 2'h1;
  localparam logic [1:0] OSEL_HIGH = 2'h2;
  localparam logic [1:0] OSEL_TOGGLE = 2'h3;
  localparam int PRESCALE_BITS = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== edge_sync.sv
/*
  Two-flop synchroniser with edge detection for the external count input.
  Assumes the input is asynchronous to sys_clk.
*/
`timescale 1ns/1ps
module edge_sync (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic async_in,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } sync_state_t;
  sync_state_t st_reg;
  sync_state_t st_next;

  // The first flop only feeds the second; edges use later stages.
  always_comb begin
    st_next = st_reg;
    st_next.meta = async_in;
    st_next.sync = st_reg.meta;
    st_next.last = st_reg.sync;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // Edge strobes are combinational from registered stages.
  assign rise = ce & st_reg.sync & ~st_reg.last;
  assign fall = ce & ~st_reg.sync & st_reg.last;
endmodule

// ===== compare_timer_assertions.sv
/*
  Port-level checker for compare_timer: bus handshakes, response timing,
  the reserved status bit and the state seen just after reset.
  Assumes it is bound to compare_timer, one clock, active-low reset.
*/
`timescale 1ns/1ps
module compare_timer_assertions (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  logic [7:0] rd_addr_reg;

  // Keep the accepted read address so the returned word can be judged.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_addr_reg <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_reg <= s_axi_araddr;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_aw_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("write response dropped before it was taken");
  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold)
    else $error("read data changed before it was taken");
  property p_bresp_legal;
    s_axi_bvalid |-> !s_axi_bresp[0];
  endproperty
  a_bresp_legal: assert property (p_bresp_legal)
    else $error("write response code not used by this slave");
  property p_rresp_legal;
    s_axi_rvalid |-> !s_axi_rresp[0];
  endproperty
  a_rresp_legal: assert property (p_rresp_legal)
    else $error("read response code not used by this slave");
  property p_wr_resp_bound;
    s_aw_taken |-> ##[0:16] s_axi_bvalid;
  endproperty
  a_wr_resp_bound: assert property (p_wr_resp_bound)
    else $error("write response late");
  property p_rd_resp_bound;
    s_ar_taken |-> ##[1:16] s_axi_rvalid;
  endproperty
  a_rd_resp_bound: assert property (p_rd_resp_bound)
    else $error("read response late");
  property p_rsvd_one;
    s_axi_rvalid && rd_addr_reg == timer_pkg::STATUS_OFF
      |-> s_axi_rdata[4] && s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_rsvd_one: assert property (p_rsvd_one)
    else $error("status word has wrong fixed bits");
  property p_reset_quiet;
    $rose(nrst) |-> !s_axi_bvalid && !s_axi_rvalid && !irq;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not idle after reset");
endmodule

bind compare_timer compare_timer_assertions u_compare_timer_assertions (
  .sys_clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .irq
);

// ===== compare_timer_tb.sv
/*
  Self-checking testbench for compare_timer: register table, flag clearing,
  output pin, interrupt, unmapped access and a second reset.
  Assumes control bits 3..1 select the count clock (7: pin, both edges).
*/
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module compare_timer_tb;
  logic sys_clk = 1'b0, nrst = 1'b0, ce = 1'b1, ext_count_in = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, timer_output_pin, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int errors = 0, compares = 0;
  typedef struct {logic [31:0] wr; logic [7:0] rd;} row_t;
  row_t rows[5] = '{'{32'h0c, 8'h1c}, '{32'h04, 8'h14}, '{32'h08, 8'h18},
                    '{32'he0, 8'h10}, '{32'h00, 8'h10}};

  compare_timer u_compare_timer (.sys_clk, .nrst, .ce, .ext_count_in,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .timer_output_pin, .irq);

  // Free-running 100 MHz clock.
  always #5 sys_clk = ~sys_clk;

  task automatic finish_test;
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Handshakes are judged at the falling edge, acted on after the rising one.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ha, hw, hb;
    int n;
    n = 0;
    hb = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!hb && n < 200) begin
      @(negedge sys_clk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid && s_axi_bready;
      @(posedge sys_clk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) s_axi_bready <= 1'b0;
      n++;
    end
    if (!hb) errors++;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rr);
    logic ha, hr;
    int n;
    n = 0;
    hr = 1'b0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!hr && n < 200) begin
      @(negedge sys_clk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid && s_axi_rready;
      v = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge sys_clk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) s_axi_rready <= 1'b0;
      n++;
    end
    if (!hr) errors++;
  endtask

  // Cut a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    finish_test;
  end

  // Main sequence: table rows first, then the hand-written cases.
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(timer_pkg::STATUS_OFF, d, r);
    `CHK(d, 32'h10)
    foreach (rows[i]) begin
      wr(timer_pkg::STATUS_OFF, rows[i].wr);
      rd(timer_pkg::STATUS_OFF, d, r);
      `CHK(d[7:0], rows[i].rd)
    end
    wr(timer_pkg::CONTROL_OFF, 32'he);
    wr(timer_pkg::COUNT_OFF, 32'hfe);
    wr(timer_pkg::CMPA_OFF, 32'hff);
    wr(timer_pkg::CMPB_OFF, 32'h00);
    wr(timer_pkg::STATUS_OFF, 32'h0c);
    // Three pin edges: 0xfe to 0xff, wrap to 0x00, then on to 0x01.
    repeat (3) begin
      @(posedge sys_clk);
      ext_count_in <= ~ext_count_in;
      repeat (8) @(posedge sys_clk);
    end
    rd(timer_pkg::COUNT_OFF, d, r);
    `CHK(d[7:0], 8'h01)
    `CHK(timer_output_pin, 1'b1)
    `CHK(irq, 1'b0)
    // A zero written before any read of a one must not clear the flags.
    wr(timer_pkg::STATUS_OFF, 32'h0c);
    rd(timer_pkg::STATUS_OFF, d, r);
    `CHK(d[7:0], 8'hfc)
    wr(timer_pkg::IRQ_MASK_OFF, 32'h7);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b1)
    wr(timer_pkg::STATUS_OFF, 32'h0c);
    rd(timer_pkg::STATUS_OFF, d, r);
    `CHK(d[7:0], 8'h1c)
    `CHK(irq, 1'b0)
    // One more pin edge from 0xff wraps and matches B, toggling back.
    wr(timer_pkg::COUNT_OFF, 32'hff);
    @(posedge sys_clk);
    ext_count_in <= ~ext_count_in;
    repeat (8) @(posedge sys_clk);
    `CHK(timer_output_pin, 1'b0)
    `CHK(irq, 1'b1)
    wr(timer_pkg::IRQ_STAT_OFF, 32'h7);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    rd(8'h1c, d, r);
    `CHK(r, timer_pkg::RESP_SLVERR)
    // Second reset in mid-run brings the status word back.
    nrst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(timer_pkg::STATUS_OFF, d, r);
    `CHK(d, 32'h10)
    finish_test;
  end
endmodule
